// [logic/alarm_matcher.sv]
// Purpose: Compares the enabled alarm fields with the current time.
// Assumes: Time bytes come from logic on the core clock.
// Notes: The hit is registered, one cycle behind the time bytes.
`timescale 1ns/1ps
module alarm_matcher (
    input wire logic clk, // core clock
    input wire logic srst, // synchronous reset, high
    input wire logic ce, // clock enable
    rtc_link_if.matcher link // match settings and time
);
    import rtc_pkg::*;

    logic [MATCH_N-1:0] fieldOn;
    logic [MATCH_N-1:0] fieldOk;
    logic matchHit;
    logic next_matchHit;

    for (genvar i = 0; i < MATCH_N; i++)
    begin : g_field
        assign fieldOn[i] = ~link.matchSet[i][OFF_BIT];
        assign fieldOk[i] = link.matchSet[i][OFF_BIT] |
            ((link.matchSet[i][6:0] & CMP_MASK[i]) ==
             (link.timeNow[i][6:0] & CMP_MASK[i]));
    end

    always_comb
    begin
        next_matchHit = (|fieldOn) & (&fieldOk);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            matchHit <= 1'b0;
        else if (ce)
            matchHit <= next_matchHit;
    end

    assign link.matchHit = matchHit;

    property p_allMatch;
        @(posedge clk) disable iff (srst)
        (ce && (|fieldOn) && (&fieldOk)) |=> matchHit;
    endproperty
    a_allMatch: assert property (p_allMatch)
        else $error("enabled alarm fields match but no hit");

    property p_noneOn;
        @(posedge clk) disable iff (srst)
        (ce && fieldOn == '0) |=> !matchHit;
    endproperty
    a_noneOn: assert property (p_noneOn)
        else $error("alarm hit with every field disabled");
endmodule : alarm_matcher

// [logic/incr_gate.sv]
// Purpose: Holds one-second increments back while the host has access.
// Assumes: tickSeen is a one-cycle pulse on the core clock.
// Notes: A single increment is kept; further ticks while held are lost.
`timescale 1ns/1ps
module incr_gate (
    input wire logic clk, // core clock
    input wire logic srst, // synchronous reset, high
    input wire logic ce, // clock enable
    rtc_link_if.gate link // tick in, increment out
);
    import rtc_pkg::*;

    gate_state_t state;
    gate_state_t next_state;
    logic incrGo;
    logic next_incrGo;

    always_comb
    begin
        next_state = state;
        next_incrGo = 1'b0;
        unique case (state)
            GATE_FREE:
            begin
                if (link.tickSeen && link.accessBusy)
                    next_state = GATE_HELD;
                else if (link.tickSeen)
                    next_incrGo = 1'b1;
            end
            GATE_HELD:
            begin
                if (!link.accessBusy)
                begin
                    next_incrGo = 1'b1;
                    // A tick in the release cycle is kept for the next.
                    next_state = link.tickSeen ? GATE_HELD : GATE_FREE;
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state <= GATE_FREE;
            incrGo <= 1'b0;
        end
        else if (ce)
        begin
            state <= next_state;
            incrGo <= next_incrGo;
        end
    end

    assign link.incrGo = incrGo;

    property p_holdBusy;
        @(posedge clk) disable iff (srst)
        (ce && link.accessBusy) |=> !incrGo;
    endproperty
    a_holdBusy: assert property (p_holdBusy)
        else $error("increment issued during host access");

    sequence s_heldRelease;
        state == GATE_HELD && !link.accessBusy && ce;
    endsequence
    property p_release;
        @(posedge clk) disable iff (srst)
        s_heldRelease |=> incrGo;
    endproperty
    a_release: assert property (p_release)
        else $error("pending increment not applied at release");
endmodule : incr_gate

// [logic/rtc_calendar_alarm_regs.sv]
// Purpose: Month and year calendar, access freeze and alarm match bank.
// Assumes: Register port and time bytes come from logic on clk.
// Notes: tickPin arrives from the oscillator domain and is synchronised.
`timescale 1ns/1ps
// Behaviour
// - Month register at 09h, top bits zero.
// - Months run BCD 1 to 12, January default.
// - Year register at 0Ah, two BCD digits.
// - Host access freezes the time counters.
// - Release applies at most one stored increment.
// - Second match at 0Bh, enable low active.
// - Minute match at 0Ch, enable low active.
// - Hour match at 0Dh, bit six unused.
// - Hour match holds 12 or 24 hour format.
// - Date match at 0Eh, bit six unused.
// - Weekday match at 0Fh, three value bits.
// - All enabled fields matching set the flag.
// - Flag sticky until cleared, set on new match.
module rtc_calendar_alarm_regs #(
    parameter int unsigned ACCESS_LIMIT_CYC = 32'(rtc_pkg::ACCESS_MAX_CYC)
) (
    input wire logic clk, // core clock, 250 MHz
    input wire logic srst, // synchronous reset, high
    input wire logic ce, // clock enable, freezes state when low
    input wire logic tickPin, // 1 Hz tick from the oscillator
    input wire logic accessBusy, // host access in progress
    input wire logic wrEn, // register write strobe
    input wire logic rdEn, // register read strobe
    input wire logic [7:0] addr, // register pointer
    input wire logic [7:0] wrData, // write data
    input wire logic [7:0] curSec, // current seconds byte
    input wire logic [7:0] curMin, // current minutes byte
    input wire logic [7:0] curHr, // current hours byte
    input wire logic [7:0] curDate, // current day byte
    input wire logic [7:0] curDow, // current weekday byte
    input wire logic monthCarry, // day counter wrapped past month end
    input wire logic flagClr, // clear the alarm flag
    output logic [7:0] rdData, // read data
    output logic rdHit, // read addressed this block
    output logic secIncr, // apply one second to the counters
    output logic [4:0] monthOut, // month register
    output logic [7:0] yearOut, // year register
    output logic alarmFlag, // alarm flag
    output logic overrunFlag // last access held too long
);
    import rtc_pkg::*;

    localparam int CNT_W = $clog2(ACCESS_LIMIT_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_LIMIT = CNT_W'(ACCESS_LIMIT_CYC);

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] regMask(input logic [7:0] a);
        logic [7:0] m;
        m = 8'h00;
        unique case (a)
            OFF_MONTH: m = MASK_MONTH;
            OFF_YEAR: m = MASK_YEAR;
            OFF_SEC_MATCH: m = MASK_SEC_MATCH;
            OFF_MIN_MATCH: m = MASK_MIN_MATCH;
            // Both hour formats share bits 5:0, so one mask serves.
            OFF_HR_MATCH: m = MASK_HR_MATCH;
            OFF_DATE_MATCH: m = MASK_DATE_MATCH;
            OFF_DOW_MATCH: m = MASK_DOW_MATCH;
            default: m = 8'h00;
        endcase
        return m;
    endfunction : regMask

    function automatic logic [4:0] bcdMonthInc(input logic [4:0] m);
        logic [4:0] r;
        r = {m[4], m[3:0] + 4'h1};
        if (m == MONTH_DEC)
            r = MONTH_JAN;
        else if (m[3:0] == BCD_NINE)
            r = MONTH_OCT;
        return r;
    endfunction : bcdMonthInc

    function automatic logic [7:0] bcdYearInc(input logic [7:0] y);
        logic [7:0] r;
        r = {y[7:4], y[3:0] + 4'h1};
        if (y[3:0] == BCD_NINE)
        begin
            r[3:0] = 4'h0;
            r[7:4] = (y[7:4] == BCD_NINE) ? 4'h0 : y[7:4] + 4'h1;
        end
        return r;
    endfunction : bcdYearInc

    // ------------------------------------------------------------------
    // Tick synchroniser and helpers
    // ------------------------------------------------------------------
    rtc_link_if link ();
    logic tickS1;
    logic tickS2;
    logic tickS3;

    assign link.tickSeen = tickS2 & ~tickS3;
    assign link.accessBusy = accessBusy;
    assign link.timeNow = {curDow, curDate, curHr, curMin, curSec};
    assign secIncr = link.incrGo;

    incr_gate u_gate (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .link(link)
    );

    alarm_matcher u_match (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .link(link)
    );

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [4:0] monthReg;
    logic [4:0] next_monthReg;
    logic [7:0] yearReg;
    logic [7:0] next_yearReg;
    logic [4:0][7:0] matchReg;
    logic [4:0][7:0] next_matchReg;
    logic [7:0] next_rdData;
    logic next_rdHit;
    logic matchPrev;
    logic next_alarmFlag;
    logic [CNT_W-1:0] busyCnt;
    logic [CNT_W-1:0] next_busyCnt;
    logic next_overrunFlag;
    logic [7:0] rawRead;
    logic [2:0] matchIdx;

    assign link.matchSet = matchReg;
    assign monthOut = monthReg;
    assign yearOut = yearReg;

    always_comb
    begin
        next_monthReg = monthReg;
        next_yearReg = yearReg;
        next_matchReg = matchReg;
        if (monthCarry)
        begin
            next_monthReg = bcdMonthInc(monthReg);
            if (monthReg == MONTH_DEC)
                next_yearReg = bcdYearInc(yearReg);
        end
        if (wrEn && addr == OFF_MONTH)
            next_monthReg = wrData[4:0];
        if (wrEn && addr == OFF_YEAR)
            next_yearReg = wrData;
        for (int i = 0; i < MATCH_N; i++)
        begin
            if (wrEn && addr == OFF_SEC_MATCH + 8'(i))
                next_matchReg[i] = wrData & regMask(addr);
        end
    end

    always_comb
    begin
        matchIdx = 3'(addr - OFF_SEC_MATCH);
        rawRead = 8'h00;
        if (addr == OFF_MONTH)
            rawRead = {3'h0, monthReg};
        else if (addr == OFF_YEAR)
            rawRead = yearReg;
        else if (addr >= OFF_SEC_MATCH && addr <= OFF_DOW_MATCH)
            rawRead = matchReg[matchIdx];
        next_rdHit = rdEn && (regMask(addr) != 8'h00);
        next_rdData = rdEn ? (rawRead & regMask(addr)) : rdData;
    end

    always_comb
    begin
        next_alarmFlag = alarmFlag;
        if (flagClr)
            next_alarmFlag = 1'b0;
        if (link.matchHit && !matchPrev)
            next_alarmFlag = 1'b1;
    end

    always_comb
    begin
        next_busyCnt = '0;
        next_overrunFlag = overrunFlag;
        if (accessBusy)
            next_busyCnt = (busyCnt == CNT_LIMIT) ? busyCnt : busyCnt + 1'b1;
        if (accessBusy && busyCnt == '0)
            next_overrunFlag = 1'b0;
        else if (busyCnt == CNT_LIMIT)
            next_overrunFlag = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            tickS1 <= 1'b0;
            tickS2 <= 1'b0;
            tickS3 <= 1'b0;
            monthReg <= RST_MONTH;
            yearReg <= RST_YEAR;
            matchReg <= {MATCH_N{RST_MATCH}};
            rdData <= 8'h00;
            rdHit <= 1'b0;
            matchPrev <= 1'b0;
            alarmFlag <= 1'b0;
            busyCnt <= '0;
            overrunFlag <= 1'b0;
        end
        else if (ce)
        begin
            tickS1 <= tickPin;
            tickS2 <= tickS1;
            tickS3 <= tickS2;
            monthReg <= next_monthReg;
            yearReg <= next_yearReg;
            matchReg <= next_matchReg;
            rdData <= next_rdData;
            rdHit <= next_rdHit;
            matchPrev <= link.matchHit;
            alarmFlag <= next_alarmFlag;
            busyCnt <= next_busyCnt;
            overrunFlag <= next_overrunFlag;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_monthRead;
        @(posedge clk) disable iff (srst)
        (ce && rdEn && addr == OFF_MONTH) |=>
            rdData == {3'h0, $past(monthReg)} && rdHit;
    endproperty
    a_monthRead: assert property (p_monthRead)
        else $error("month readback wrong or upper bits set");

    property p_rstCal;
        @(posedge clk) disable iff (srst)
        $fell(srst) |-> monthReg == MONTH_JAN && yearReg == 8'h00;
    endproperty
    a_rstCal: assert property (p_rstCal)
        else $error("calendar not January 00 after reset");

    property p_yearWrite;
        @(posedge clk) disable iff (srst)
        (ce && wrEn && addr == OFF_YEAR) |=> yearReg == $past(wrData);
    endproperty
    a_yearWrite: assert property (p_yearWrite)
        else $error("year write not stored");

    property p_decWrap;
        @(posedge clk) disable iff (srst)
        (ce && monthCarry && !wrEn && monthReg == MONTH_DEC) |=>
            monthReg == MONTH_JAN && yearReg == bcdYearInc($past(yearReg));
    endproperty
    a_decWrap: assert property (p_decWrap)
        else $error("December rollover wrong");

    property p_yearWrap;
        @(posedge clk) disable iff (srst)
        (ce && monthCarry && !wrEn && monthReg == MONTH_DEC &&
         yearReg == 8'h99) |=> yearReg == 8'h00;
    endproperty
    a_yearWrap: assert property (p_yearWrap)
        else $error("year 99 did not wrap to 00");

    property p_matchRst;
        @(posedge clk) disable iff (srst)
        $fell(srst) |-> matchReg == {MATCH_N{RST_MATCH}};
    endproperty
    a_matchRst: assert property (p_matchRst)
        else $error("match fields not disabled after reset");

    property p_minWrite;
        @(posedge clk) disable iff (srst)
        (ce && wrEn && addr == OFF_MIN_MATCH) |=>
            matchReg[1] == $past(wrData);
    endproperty
    a_minWrite: assert property (p_minWrite)
        else $error("minute match write not stored");

    property p_hrWrite;
        @(posedge clk) disable iff (srst)
        (ce && wrEn && addr == OFF_HR_MATCH) |=>
            matchReg[2] == ($past(wrData) & MASK_HR_MATCH);
    endproperty
    a_hrWrite: assert property (p_hrWrite)
        else $error("hour match write wrong or bit 6 kept");

    property p_dateWrite;
        @(posedge clk) disable iff (srst)
        (ce && wrEn && addr == OFF_DATE_MATCH) |=> !matchReg[3][6];
    endproperty
    a_dateWrite: assert property (p_dateWrite)
        else $error("date match bit 6 not zero");

    property p_dowWrite;
        @(posedge clk) disable iff (srst)
        (ce && wrEn && addr == OFF_DOW_MATCH) |=>
            matchReg[4] == ($past(wrData) & MASK_DOW_MATCH);
    endproperty
    a_dowWrite: assert property (p_dowWrite)
        else $error("weekday match write wrong");

    sequence s_newHit;
        ce && link.matchHit && !matchPrev;
    endsequence
    property p_flagSet;
        @(posedge clk) disable iff (srst)
        s_newHit |=> alarmFlag;
    endproperty
    a_flagSet: assert property (p_flagSet)
        else $error("new match did not set the alarm flag");

    property p_flagHold;
        @(posedge clk) disable iff (srst)
        (ce && alarmFlag && !flagClr) |=> alarmFlag;
    endproperty
    a_flagHold: assert property (p_flagHold)
        else $error("alarm flag dropped without a clear");
endmodule : rtc_calendar_alarm_regs

// [logic/rtc_link_if.sv]
// Purpose: Carries signals between the calendar core and its helpers.
// Assumes: All members live on the core clock.
// Notes: Index 0 of the byte arrays is seconds.
`timescale 1ns/1ps
interface rtc_link_if;
    logic tickSeen;
    logic accessBusy;
    logic incrGo;
    logic [4:0][7:0] matchSet;
    logic [4:0][7:0] timeNow;
    logic matchHit;
    modport gate (input tickSeen, input accessBusy, output incrGo);
    modport matcher (input matchSet, input timeNow, output matchHit);
    modport core (output tickSeen, output accessBusy, output matchSet,
                  output timeNow, input incrGo, input matchHit);
endinterface : rtc_link_if

// [logic/rtc_pkg.sv]
// Purpose: Shared constants and types of the calendar and alarm block.
// Assumes: Byte-wide registers addressed by an 8-bit register pointer.
// Notes: Match register index 0 is seconds, 4 is weekday.
package rtc_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_MONTH = 8'h09;
    localparam logic [7:0] OFF_YEAR = 8'h0a;
    localparam logic [7:0] OFF_SEC_MATCH = 8'h0b;
    localparam logic [7:0] OFF_MIN_MATCH = 8'h0c;
    localparam logic [7:0] OFF_HR_MATCH = 8'h0d;
    localparam logic [7:0] OFF_DATE_MATCH = 8'h0e;
    localparam logic [7:0] OFF_DOW_MATCH = 8'h0f;
    localparam int MATCH_N = 5;
    localparam int OFF_BIT = 7;
    // ------------------------------------------------------------------
    // Implemented bits and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] MASK_MONTH = 8'h1f;
    localparam logic [7:0] MASK_YEAR = 8'hff;
    localparam logic [7:0] MASK_SEC_MATCH = 8'hff;
    localparam logic [7:0] MASK_MIN_MATCH = 8'hff;
    localparam logic [7:0] MASK_HR_MATCH = 8'hbf;
    localparam logic [7:0] MASK_DATE_MATCH = 8'hbf;
    localparam logic [7:0] MASK_DOW_MATCH = 8'h87;
    localparam logic [4:0][6:0] CMP_MASK = {7'h07, 7'h3f, 7'h3f, 7'h7f,
                                            7'h7f};
    localparam logic [4:0] RST_MONTH = 5'h01;
    localparam logic [7:0] RST_YEAR = 8'h00;
    localparam logic [7:0] RST_MATCH = 8'h80;
    localparam logic [4:0] MONTH_JAN = 5'h01;
    localparam logic [4:0] MONTH_OCT = 5'h10;
    localparam logic [4:0] MONTH_DEC = 5'h12;
    localparam logic [3:0] BCD_NINE = 4'h9;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam longint ACCESS_MAX_NS = 1000000000;
    localparam longint CLK_PERIOD_NS = 4;
    localparam longint ACCESS_MAX_CYC = ACCESS_MAX_NS / CLK_PERIOD_NS;
    typedef enum {GATE_FREE, GATE_HELD} gate_state_t;
endpackage : rtc_pkg

// [verification/host_model.sv]
// Purpose: Host side of the register port of the calendar block.
// Assumes: One access at a time, one strobe per byte.
// Notes: Between bytes the pointer and data show the inverse value.
`timescale 1ns/1ps
module host_model (
    input wire logic clk, // core clock
    output logic accessBusy, // access in progress
    output logic wrEn, // write strobe
    output logic rdEn, // read strobe
    output logic [7:0] addr, // register pointer
    output logic [7:0] wrData // write data
);
    initial
    begin
        accessBusy = 1'b0;
        wrEn = 1'b0;
        rdEn = 1'b0;
        addr = 8'h00;
        wrData = 8'h00;
    end

    task automatic busy(input logic b);
        @(posedge clk);
        #1 accessBusy = b;
    endtask : busy

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
        @(posedge clk);
        #1 wrEn = w;
        rdEn = !w;
        addr = a;
        wrData = d;
        @(posedge clk);
        #1 wrEn = 1'b0;
        rdEn = 1'b0;
        addr = ~a;
        wrData = ~d;
    endtask : xfer
endmodule : host_model

// [verification/rtc_calendar_alarm_regs_tb.sv]
// Purpose: Self-checking bench of the calendar and alarm block.
// Assumes: Host model drives the register port; bench drives the rest.
// Notes: Access limit shortened to 20 cycles to keep the run short.
`timescale 1ns/1ps
module rtc_calendar_alarm_regs_tb;
    import rtc_pkg::*;
    localparam logic [7:0] MSK [0:6] = '{MASK_MONTH, MASK_YEAR,
        MASK_SEC_MATCH, MASK_MIN_MATCH, MASK_HR_MATCH, MASK_DATE_MATCH,
        MASK_DOW_MATCH};
    logic clk = 1'b0;
    logic srst, ce, tickPin, accessBusy, wrEn, rdEn, monthCarry, flagClr;
    logic [7:0] addr, wrData, rdData, yearOut;
    logic [7:0] cur [5];
    logic [7:0] curSec, curMin, curHr, curDate, curDow;
    logic rdHit, secIncr, alarmFlag, overrunFlag;
    logic [4:0] monthOut;
    int mdl [16];
    int error_cnt = 0;
    int compares = 0;
    int incCnt = 0;

    always #2 clk = ~clk;
    // Counted on the falling edge, where the registered pulse has settled.
    always @(negedge clk) if (secIncr === 1'b1) incCnt++;
    always_comb {curDow, curDate, curHr, curMin, curSec} =
        {cur[4], cur[3], cur[2], cur[1], cur[0]};

    host_model u_host_model (.clk(clk), .accessBusy(accessBusy),
        .wrEn(wrEn), .rdEn(rdEn), .addr(addr), .wrData(wrData));

    rtc_calendar_alarm_regs #(.ACCESS_LIMIT_CYC(20))
    u_rtc_calendar_alarm_regs (.clk(clk), .srst(srst), .ce(ce),
        .tickPin(tickPin), .accessBusy(accessBusy), .wrEn(wrEn),
        .rdEn(rdEn), .addr(addr), .wrData(wrData), .curSec(curSec),
        .curMin(curMin), .curHr(curHr), .curDate(curDate),
        .curDow(curDow), .monthCarry(monthCarry), .flagClr(flagClr),
        .rdData(rdData), .rdHit(rdHit), .secIncr(secIncr),
        .monthOut(monthOut), .yearOut(yearOut), .alarmFlag(alarmFlag),
        .overrunFlag(overrunFlag));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string n, input int e, input logic [7:0] s);
        compares++;
        if (s !== 8'(e))
        begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, 8'(e), s);
        end
    endtask : chk

    task automatic final_report();
        if (error_cnt == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt

    task automatic reg_wr(input int a, input logic [7:0] d);
        u_host_model.xfer(1'b1, 8'(a), d);
        if (a >= 9 && a <= 15)
            mdl[a] = d & MSK[a - 9];
    endtask : reg_wr

    // Read data must show the model value; unmapped places read zero.
    task automatic reg_rd(input int a);
        logic hit;
        hit = a >= 9 && a <= 15;
        u_host_model.xfer(1'b0, 8'(a), 8'h00);
        chk("rdData", hit ? mdl[a] : 0, rdData);
        chk("rdHit", int'(hit), {7'h00, rdHit});
    endtask : reg_rd

    function automatic int bcd_inc(input int v);
        return (v % 16 == 9) ? ((v / 16 + 1) % 10) * 16 : v + 1;
    endfunction : bcd_inc

    task automatic carry();
        @(posedge clk);
        #1 monthCarry = 1'b1;
        @(posedge clk);
        #1 monthCarry = 1'b0;
        if (mdl[9] == 'h12)
        begin
            mdl[9] = 1;
            mdl[10] = bcd_inc(mdl[10]);
        end
        else
            mdl[9] = bcd_inc(mdl[9]);
        chk("monthOut", mdl[9], {3'b000, monthOut});
        chk("yearOut", mdl[10], yearOut);
    endtask : carry

    task automatic tick();
        @(posedge clk);
        #1 tickPin = 1'b1;
        wt(2);
        tickPin = 1'b0;
        wt(2);
    endtask : tick

    task automatic pulse_clr();
        @(posedge clk);
        #1 flagClr = 1'b1;
        @(posedge clk);
        #1 flagClr = 1'b0;
    endtask : pulse_clr

    initial
    begin
        #80000;
        error_cnt++;
        final_report();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        int c;
        void'($urandom(32'h95ead921));
        srst = 1'b1;
        ce = 1'b1;
        tickPin = 1'b0;
        monthCarry = 1'b0;
        flagClr = 1'b0;
        for (int i = 0; i < 5; i++) cur[i] = 8'h00;
        wt(5);
        srst = 1'b0;
        mdl[9] = RST_MONTH;
        mdl[10] = RST_YEAR;
        for (int a = 11; a <= 15; a++) mdl[a] = RST_MATCH;
        for (int a = 9; a <= 16; a++) reg_rd(a);
        for (int a = 9; a <= 16; a++) reg_wr(a, 8'($urandom));
        for (int a = 9; a <= 16; a++) reg_rd(a);
        reg_wr(9, 8'h01);
        reg_wr(10, 8'h99);
        for (int m = 0; m < 13; m++) carry();
        chk("incCnt", 0, 8'(incCnt));
        tick();
        wt(4);
        chk("incCnt", 1, 8'(incCnt));
        u_host_model.busy(1'b1);
        tick();
        tick();
        chk("incCnt", 1, 8'(incCnt));
        u_host_model.busy(1'b0);
        wt(4);
        chk("incCnt", 2, 8'(incCnt));
        chk("overrun", 0, {7'h00, overrunFlag});
        u_host_model.busy(1'b1);
        wt(25);
        u_host_model.busy(1'b0);
        wt(1);
        chk("overrun", 1, {7'h00, overrunFlag});
        u_host_model.busy(1'b1);
        u_host_model.busy(1'b0);
        wt(1);
        chk("overrun", 0, {7'h00, overrunFlag});
        // A write while the clock enable is low must leave the year alone.
        @(posedge clk);
        #1 ce = 1'b0;
        u_host_model.xfer(1'b1, OFF_YEAR, 8'h42);
        wt(1);
        ce = 1'b1;
        chk("yearFrozen", mdl[10], yearOut);
        for (int a = 11; a <= 15; a++) reg_wr(a, 8'h80);
        pulse_clr();
        for (int i = 0; i < 5; i++)
        begin
            for (int k = 0; k < 5; k++) cur[k] = 8'($urandom);
            wt(4);
            chk("alarmOff", 0, {7'h00, alarmFlag});
            reg_wr(11 + i, cur[i] & 8'h7f);
            wt(4);
            chk("alarmHit", 1, {7'h00, alarmFlag});
            pulse_clr();
            wt(4);
            chk("alarmHeld", 0, {7'h00, alarmFlag});
            cur[i] = cur[i] ^ 8'h01;
            wt(4);
            chk("alarmMiss", 0, {7'h00, alarmFlag});
            cur[i] = cur[i] ^ 8'h01;
            wt(4);
            chk("alarmAgain", 1, {7'h00, alarmFlag});
            c = 11 + i;
            reg_rd(c);
            reg_wr(c, 8'h80);
            pulse_clr();
        end
        final_report();
    end
endmodule : rtc_calendar_alarm_regs_tb
